// ### exc_regs.svh
// Register offsets, field positions, reset values and counts of the exception/reset sequencer.
`ifndef EXC_SEQ_REGS_SVH
`define EXC_SEQ_REGS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets on the AHB-Lite slave.
// ----------------------------------------------------------------------------
`define EXC_REG_MODE 8'h00
`define EXC_REG_WDCTL 8'h04
`define EXC_REG_STATUS 8'h08
`define EXC_REG_PC 8'h0c
`define EXC_REG_CP 8'h10
`define EXC_ADDR_LSB 0
`define EXC_ADDR_MSB 7

// ----------------------------------------------------------------------------
// Watchdog reset control/status fields.
// ----------------------------------------------------------------------------
`define EXC_WD_OE_BIT 0
`define EXC_WD_MODE_BIT 1
`define EXC_WD_FLAG_BIT 7
`define EXC_WDCTL_RESET 8'h00

// ----------------------------------------------------------------------------
// Status word fields and reset values.
// ----------------------------------------------------------------------------
`define EXC_SR_T_BIT 15
`define EXC_SR_I_MSB 10
`define EXC_SR_I_LSB 8
`define EXC_SR_RESET 16'h0700
`define EXC_IMASK_ALL 3'h7

// ----------------------------------------------------------------------------
// Sequencing constants.
// ----------------------------------------------------------------------------
`define EXC_WD_PIN_CYCLES 8'h84
`define EXC_VEC_RESET 8'h00
`define EXC_WORD_STEP 16'h0002
`define EXC_PUSH_LAST_MIN 2'h1
`define EXC_PUSH_LAST_MAX 2'h2
`define EXC_PUSH_PC 2'h0
`define EXC_PUSH_MID 2'h1
`define EXC_BLOCK_ONE 2'h1
`define EXC_HTRANS_NONSEQ_BIT 1

`endif

// ### exc_pkg.sv
// Types shared by the exception/reset sequencer.
package exc_pkg;
   // One-hot sequencer states.
   typedef enum logic [5:0] {
      EXC_ST_RESET  = 6'b000001,
      EXC_ST_IDLE   = 6'b000010,
      EXC_ST_PUSH   = 6'b000100,
      EXC_ST_VEC0   = 6'b001000,
      EXC_ST_VEC1   = 6'b010000,
      EXC_ST_BRANCH = 6'b100000
   } exc_state_t;
endpackage

// ### exc_reset_sequencer.sv
// Exception-entry and reset sequencer with an AHB-Lite register slave.
`timescale 1ns/10ps
`include "exc_regs.svh"

module exc_reset_sequencer
   import exc_pkg::*;
#(
   parameter logic [7:0] MAX_MODE_MASK = 8'hf0
) (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic external_init_pin_n_in,
   output logic external_init_pin_out,
   output logic external_init_pin_oe_out,
   input wire logic [2:0] mode_select_pins_in,
   input wire logic wdog_overflow_in,
   output logic chip_init_out,
   output logic cpu_halt_out,
   input wire logic exc_req_in,
   input wire logic [7:0] exc_vec_in,
   input wire logic exc_is_irq_in,
   input wire logic [2:0] exc_irq_level_in,
   output logic exc_ack_out,
   output logic branch_out,
   output logic irq_block_out,
   input wire logic insn_done_in,
   input wire logic load_ctrl_insn_in,
   input wire logic sr_load_in,
   input wire logic [15:0] sr_wdata_in,
   input wire logic [15:0] pc_in,
   input wire logic [15:0] sp_in,
   output logic [15:0] sp_out,
   output logic sp_we_out,
   output logic [15:0] status_word_out,
   output logic [15:0] pc_out,
   output logic [7:0] code_page_reg_out,
   output logic [2:0] latched_mode_bits_out,
   output logic mem_req_out,
   output logic mem_we_out,
   output logic [15:0] mem_addr_out,
   output logic [15:0] mem_wdata_out,
   input wire logic [15:0] mem_rdata_in,
   input wire logic mem_ack_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out
);

   // ----------------------------------------------------------------------------
   // Declarations.
   // ----------------------------------------------------------------------------
   exc_state_t state_ff;
   exc_state_t nxt_state;
   logic [7:0] wd_cnt_ff;
   logic [7:0] wdctl_ff;
   logic [2:0] mode_ff;
   logic [15:0] sr_ff;
   logic [15:0] pc_ff;
   logic [7:0] cp_ff;
   logic [15:0] sp_ff;
   logic sp_we_ff;
   logic [1:0] push_idx_ff;
   logic [7:0] vec_ff;
   logic is_irq_ff;
   logic is_reset_ff;
   logic [2:0] level_ff;
   logic [1:0] blk_cnt_ff;
   logic irq_block_ff;
   logic ack_ff;
   logic branch_ff;
   logic halt_ff;
   logic init_ff;
   logic pin_oe_ff;
   logic pin_out_ff;
   logic mem_req_ff;
   logic mem_we_ff;
   logic [15:0] mem_addr_ff;
   logic [15:0] mem_wdata_ff;
   logic [31:0] hrdata_ff;
   logic hreadyout_ff;
   logic wr_pend_ff;
   logic [7:0] wr_addr_ff;
   logic pin_low;
   logic chip_rst;
   logic max_mode;
   logic mem_done;
   logic take_exc;
   logic push_last;
   logic ahb_go;
   logic [15:0] vec_base;
   logic [15:0] push_data;
   logic [1:0] push_end;

   // ----------------------------------------------------------------------------
   // Reset sources and mode decode.
   // ----------------------------------------------------------------------------
   // Our own drive of the pin reads back low; ignoring it then keeps the control register alive.
   assign pin_low = !external_init_pin_n_in && !pin_oe_ff;
   assign chip_rst = pin_low || (wd_cnt_ff != 8'h00);
   assign max_mode = MAX_MODE_MASK[mode_ff];
   assign mem_done = mem_req_ff && mem_ack_in;
   // Interrupts, NMI included, wait while blocked; instruction exceptions always enter.
   assign take_exc = exc_req_in && (!exc_is_irq_in || blk_cnt_ff == 2'h0);
   assign push_end = max_mode ? `EXC_PUSH_LAST_MAX : `EXC_PUSH_LAST_MIN;
   assign push_last = push_idx_ff == push_end;
   // Vector spacing doubles in maximum mode.
   assign vec_base = max_mode ? {6'h00, vec_ff, 2'b00} : {7'h00, vec_ff, 1'b0};
   assign ahb_go = hsel_in && hready_in && htrans_in[`EXC_HTRANS_NONSEQ_BIT];

   // Push order: PC first, then code page in maximum mode, status word last.
   always_comb begin
      push_data = sr_ff;
      if (push_idx_ff == `EXC_PUSH_PC) begin
         push_data = pc_in;
      end else if (push_idx_ff == `EXC_PUSH_MID && max_mode) begin
         push_data = {8'h00, cp_ff};
      end
   end

   // ----------------------------------------------------------------------------
   // Sequencer state machine.
   // ----------------------------------------------------------------------------
   // A live reset condition overrides any state, so nothing else can win against it.
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         EXC_ST_RESET: begin
            if (!chip_rst) begin
               nxt_state = EXC_ST_VEC0;
            end
         end
         EXC_ST_IDLE: begin
            if (take_exc) begin
               nxt_state = EXC_ST_PUSH;
            end
         end
         EXC_ST_PUSH: begin
            if (mem_done && push_last) begin
               nxt_state = EXC_ST_VEC0;
            end
         end
         EXC_ST_VEC0: begin
            if (mem_done) begin
               nxt_state = max_mode ? EXC_ST_VEC1 : EXC_ST_BRANCH;
            end
         end
         EXC_ST_VEC1: begin
            if (mem_done) begin
               nxt_state = EXC_ST_BRANCH;
            end
         end
         EXC_ST_BRANCH: begin
            nxt_state = EXC_ST_IDLE;
         end
         default: begin
            nxt_state = EXC_ST_RESET;
         end
      endcase
      if (chip_rst) begin
         nxt_state = EXC_ST_RESET;
      end
   end

   // State register.
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_ff <= EXC_ST_RESET;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ----------------------------------------------------------------------------
   // Watchdog reset timer and init pin drive.
   // ----------------------------------------------------------------------------
   // The internal reset lasts the pin pulse length whether or not the pin is driven.
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wd_cnt_ff <= 8'h00;
         pin_oe_ff <= 1'b0;
         pin_out_ff <= 1'b0;
      end else begin
         pin_out_ff <= 1'b0;
         if (wdog_overflow_in && wdctl_ff[`EXC_WD_MODE_BIT] && wd_cnt_ff == 8'h00 && !pin_low) begin
            wd_cnt_ff <= `EXC_WD_PIN_CYCLES;
            pin_oe_ff <= wdctl_ff[`EXC_WD_OE_BIT];
         end else if (wd_cnt_ff != 8'h00) begin
            wd_cnt_ff <= wd_cnt_ff - 8'h01;
            pin_oe_ff <= pin_oe_ff && (wd_cnt_ff != 8'h01);
         end
      end
   end

   // Init follows the combined reset condition; halt is registered from the next state, so it is high whenever the state is not idle.
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         halt_ff <= 1'b1;
         init_ff <= 1'b1;
      end else begin
         halt_ff <= nxt_state != EXC_ST_IDLE;
         init_ff <= chip_rst;
      end
   end

   // ----------------------------------------------------------------------------
   // Mode latch and watchdog control register.
   // ----------------------------------------------------------------------------
   // Mode bits are caught once, as the reset sequence begins, and then held.
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mode_ff <= 3'h0;
      end else if (state_ff == EXC_ST_RESET && !chip_rst) begin
         mode_ff <= mode_select_pins_in;
      end
   end

   // Only a pin reset clears this register, so the watchdog flag survives its own reset.
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wdctl_ff <= `EXC_WDCTL_RESET;
      end else if (pin_low) begin
         wdctl_ff <= `EXC_WDCTL_RESET;
      end else begin
         if (wr_pend_ff && wr_addr_ff == `EXC_REG_WDCTL) begin
            wdctl_ff[`EXC_WD_OE_BIT] <= hwdata_in[`EXC_WD_OE_BIT];
            wdctl_ff[`EXC_WD_MODE_BIT] <= hwdata_in[`EXC_WD_MODE_BIT];
            wdctl_ff[`EXC_WD_FLAG_BIT] <= wdctl_ff[`EXC_WD_FLAG_BIT] && hwdata_in[`EXC_WD_FLAG_BIT];
         end
         // Set wins over a clear in the same cycle.
         if (wdog_overflow_in && wdctl_ff[`EXC_WD_MODE_BIT] && wd_cnt_ff == 8'h00) begin
            wdctl_ff[`EXC_WD_FLAG_BIT] <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Status word, program counter and code page.
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sr_ff <= `EXC_SR_RESET;
      end else if (chip_rst || (state_ff == EXC_ST_RESET)) begin
         sr_ff <= `EXC_SR_RESET;
      end else if (state_ff == EXC_ST_PUSH && mem_done && push_last) begin
         // Trace clears only after the old word is stacked, so the saved copy keeps it.
         sr_ff[`EXC_SR_T_BIT] <= 1'b0;
         if (is_irq_ff) begin
            sr_ff[`EXC_SR_I_MSB:`EXC_SR_I_LSB] <= level_ff;
         end
      end else if (sr_load_in && state_ff == EXC_ST_IDLE) begin
         sr_ff <= sr_wdata_in;
      end
   end

   // Handler address loads; maximum mode takes the page from the low byte of the first word.
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pc_ff <= 16'h0000;
         cp_ff <= 8'h00;
      end else if (chip_rst) begin
         pc_ff <= 16'h0000;
         cp_ff <= 8'h00;
      end else if (state_ff == EXC_ST_VEC0 && mem_done) begin
         if (max_mode) begin
            cp_ff <= mem_rdata_in[7:0];
         end else begin
            pc_ff <= mem_rdata_in;
         end
      end else if (state_ff == EXC_ST_VEC1 && mem_done) begin
         pc_ff <= mem_rdata_in;
      end
   end

   // ----------------------------------------------------------------------------
   // Request capture, stack pointer and interrupt blocking.
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         vec_ff <= `EXC_VEC_RESET;
         is_irq_ff <= 1'b0;
         is_reset_ff <= 1'b1;
         level_ff <= 3'h0;
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= 1'b0;
         if (chip_rst) begin
            vec_ff <= `EXC_VEC_RESET;
            is_irq_ff <= 1'b0;
            is_reset_ff <= 1'b1;
         end else if (state_ff == EXC_ST_IDLE && take_exc) begin
            vec_ff <= exc_vec_in;
            is_irq_ff <= exc_is_irq_in;
            is_reset_ff <= 1'b0;
            level_ff <= exc_irq_level_in;
            ack_ff <= 1'b1;
         end
      end
   end

   // The stack pointer is only sampled and moved by pushes; reset leaves it alone.
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sp_ff <= 16'h0000;
         sp_we_ff <= 1'b0;
         push_idx_ff <= `EXC_PUSH_PC;
      end else begin
         sp_we_ff <= 1'b0;
         if (state_ff == EXC_ST_IDLE && take_exc && !chip_rst) begin
            sp_ff <= sp_in - `EXC_WORD_STEP;
            push_idx_ff <= `EXC_PUSH_PC;
         end else if (state_ff == EXC_ST_PUSH && mem_done && !chip_rst) begin
            push_idx_ff <= push_idx_ff + 2'h1;
            if (push_last) begin
               sp_we_ff <= 1'b1;
            end else begin
               sp_ff <= sp_ff - `EXC_WORD_STEP;
            end
         end
      end
   end

   // Count of instruction completions still to pass before interrupts are accepted.
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         blk_cnt_ff <= `EXC_BLOCK_ONE;
         irq_block_ff <= 1'b1;
      end else if (chip_rst || state_ff == EXC_ST_RESET) begin
         blk_cnt_ff <= `EXC_BLOCK_ONE;
         irq_block_ff <= 1'b1;
      end else if (state_ff == EXC_ST_BRANCH && is_reset_ff) begin
         blk_cnt_ff <= `EXC_BLOCK_ONE;
         irq_block_ff <= 1'b1;
      end else if (load_ctrl_insn_in) begin
         blk_cnt_ff <= `EXC_BLOCK_ONE;
         irq_block_ff <= 1'b1;
      end else if (insn_done_in && blk_cnt_ff != 2'h0) begin
         blk_cnt_ff <= blk_cnt_ff - 2'h1;
         irq_block_ff <= blk_cnt_ff != 2'h1;
      end
   end

   // ----------------------------------------------------------------------------
   // Memory port.
   // ----------------------------------------------------------------------------
   // Request drops for one cycle after each acknowledge so the next address is settled.
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mem_req_ff <= 1'b0;
         mem_we_ff <= 1'b0;
         mem_addr_ff <= 16'h0000;
         mem_wdata_ff <= 16'h0000;
         branch_ff <= 1'b0;
      end else begin
         branch_ff <= state_ff == EXC_ST_BRANCH && !chip_rst;
         mem_req_ff <= !chip_rst && !mem_done &&
                       (state_ff == EXC_ST_PUSH || state_ff == EXC_ST_VEC0 || state_ff == EXC_ST_VEC1);
         mem_we_ff <= state_ff == EXC_ST_PUSH;
         mem_wdata_ff <= push_data;
         if (state_ff == EXC_ST_PUSH) begin
            mem_addr_ff <= sp_ff;
         end else if (state_ff == EXC_ST_VEC1) begin
            mem_addr_ff <= vec_base + `EXC_WORD_STEP;
         end else begin
            mem_addr_ff <= vec_base;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // AHB-Lite register slave.
   // ----------------------------------------------------------------------------
   // Zero wait states: read data is prepared at the address phase.
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         hrdata_ff <= 32'h00000000;
         hreadyout_ff <= 1'b1;
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
      end else begin
         hreadyout_ff <= 1'b1;
         wr_pend_ff <= ahb_go && hwrite_in;
         wr_addr_ff <= haddr_in[`EXC_ADDR_MSB:`EXC_ADDR_LSB];
         hrdata_ff <= 32'h00000000;
         if (ahb_go && !hwrite_in && haddr_in[31:8] == 24'h000000) begin
            case (haddr_in[`EXC_ADDR_MSB:`EXC_ADDR_LSB])
               `EXC_REG_MODE: hrdata_ff <= {29'h00000000, mode_ff};
               `EXC_REG_WDCTL: hrdata_ff <= {24'h000000, wdctl_ff};
               `EXC_REG_STATUS: hrdata_ff <= {16'h0000, sr_ff};
               `EXC_REG_PC: hrdata_ff <= {16'h0000, pc_ff};
               `EXC_REG_CP: hrdata_ff <= {24'h000000, cp_ff};
               default: hrdata_ff <= 32'h00000000;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------------
   // Output assignments.
   // ----------------------------------------------------------------------------
   assign external_init_pin_out = pin_out_ff;
   assign external_init_pin_oe_out = pin_oe_ff;
   assign chip_init_out = init_ff;
   assign cpu_halt_out = halt_ff;
   assign exc_ack_out = ack_ff;
   assign branch_out = branch_ff;
   assign irq_block_out = irq_block_ff;
   assign sp_out = sp_ff;
   assign sp_we_out = sp_we_ff;
   assign status_word_out = sr_ff;
   assign pc_out = pc_ff;
   assign code_page_reg_out = cp_ff;
   assign latched_mode_bits_out = mode_ff;
   assign mem_req_out = mem_req_ff;
   assign mem_we_out = mem_we_ff;
   assign mem_addr_out = mem_addr_ff;
   assign mem_wdata_out = mem_wdata_ff;
   assign hrdata_out = hrdata_ff;
   assign hreadyout_out = hreadyout_ff;
   assign hresp_out = 1'b0;

endmodule

// ### exc_seq_chk_sva.sv
// Concurrent checks on the ports of the exception/reset sequencer.
`timescale 1ns/10ps
module exc_seq_chk
   import exc_pkg::*;
#(
   parameter logic [7:0] MAX_MODE_MASK = 8'hf0
) (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic external_init_pin_n_in,
   input wire logic external_init_pin_oe_out,
   input wire logic chip_init_out,
   input wire logic cpu_halt_out,
   input wire logic exc_ack_out,
   input wire logic branch_out,
   input wire logic irq_block_out,
   input wire logic load_ctrl_insn_in,
   input wire logic sp_we_out,
   input wire logic [15:0] sp_in,
   input wire logic [15:0] sp_out,
   input wire logic [15:0] status_word_out,
   input wire logic [2:0] latched_mode_bits_out
);
   logic [7:0] oe_cnt_ff;
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_n_in);
   // Counts pin drive cycles, since 132 is far too long to unroll as a repetition.
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         oe_cnt_ff <= 8'h00;
      end else begin
         oe_cnt_ff <= external_init_pin_oe_out ? oe_cnt_ff + 8'h01 : 8'h00;
      end
   end
   sequence s_init_end;
      $fell(chip_init_out);
   endsequence
   sequence s_boot;
      s_init_end ##[1:40] branch_out;
   endsequence
   chk_ack_pulse: assert property (exc_ack_out |=> !exc_ack_out)
      else $error("Request ack lasted more than one cycle.");
   chk_pin_reset: assert property (!external_init_pin_n_in && !external_init_pin_oe_out |=>
      chip_init_out && cpu_halt_out && !exc_ack_out) else $error("Low init pin did not hold the core in reset.");
   chk_reset_nopush: assert property (s_init_end |-> (!sp_we_out)[*8])
      else $error("Reset sequence moved the stack pointer.");
   chk_reset_fetch: assert property (s_init_end |-> ##[1:40] branch_out)
      else $error("Reset sequence did not branch in time.");
   chk_boot_block: assert property (s_boot |-> irq_block_out && status_word_out == 16'h0700)
      else $error("Boot branch without interrupt block or mask seven.");
   chk_branch_trace: assert property (branch_out |-> !status_word_out[15] && !$past(branch_out))
      else $error("Branch with trace flag set or longer than one cycle.");
   chk_sp_step: assert property (sp_we_out |->
      sp_out == sp_in - (MAX_MODE_MASK[latched_mode_bits_out] ? 16'h0006 : 16'h0004))
      else $error("Stack pointer step does not match the push count.");
   chk_wdog_pin: assert property ($fell(external_init_pin_oe_out) && oe_cnt_ff != 8'h00 |-> oe_cnt_ff == 8'h84)
      else $error("Init pin drive length is not 132 cycles.");
   chk_ldc_block: assert property (load_ctrl_insn_in |=> irq_block_out)
      else $error("Load-control instruction did not block interrupts.");
endmodule
bind exc_reset_sequencer exc_seq_chk #(.MAX_MODE_MASK(MAX_MODE_MASK)) u_exc_seq_chk (.clk_sys_in, .rst_n_in,
   .external_init_pin_n_in, .external_init_pin_oe_out, .chip_init_out, .cpu_halt_out, .exc_ack_out, .branch_out,
   .irq_block_out, .load_ctrl_insn_in, .sp_we_out, .sp_in, .sp_out, .status_word_out, .latched_mode_bits_out);

// ### exc_mem_model.sv
// Word memory on the far side of the sequencer's stack and vector port.
`timescale 1ns/10ps
module exc_mem_model (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic req_in,
   input wire logic we_in,
   input wire logic [15:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic slow_in,
   output logic ack_out,
   output logic [15:0] rdata_out
);
   logic [15:0] mem [0:255];
   logic [1:0] wait_ff;
   // One ack per request, three cycles late when slow; read data is scrambled outside the ack.
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ack_out <= 1'b0;
         wait_ff <= 2'h0;
         rdata_out <= 16'h0000;
      end else if (req_in && !ack_out && (!slow_in || wait_ff == 2'h3)) begin
         ack_out <= 1'b1;
         wait_ff <= 2'h0;
         rdata_out <= mem[addr_in[8:1]];
         if (we_in) begin
            mem[addr_in[8:1]] <= wdata_in;
         end
      end else begin
         ack_out <= 1'b0;
         wait_ff <= (req_in && !ack_out) ? wait_ff + 2'h1 : 2'h0;
         rdata_out <= ~rdata_out;
      end
   end
endmodule

// ### testbench.sv
// Self-checking bench for the exception/reset sequencer.
`timescale 1ns/10ps
`include "exc_regs.svh"
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin fails++; \
   $display("MISMATCH %s exp %h got %h", n, e, s); end end
module testbench;
   import exc_pkg::*;
   logic clk_sys_in = 1'b0, rst_n_in = 1'b0, pin_drv = 1'b1, slow = 1'b0, wdog_overflow_in = 1'b0, hsel_in = 1'b0;
   logic exc_req_in = 1'b0, exc_is_irq_in = 1'b0, insn_done_in = 1'b0, load_ctrl_insn_in = 1'b0, sr_load_in = 1'b0;
   logic hwrite_in = 1'b0, external_init_pin_n_in, hready_in;
   logic [1:0] htrans_in = 2'h0;
   logic [2:0] mode_select_pins_in = 3'h0, exc_irq_level_in = 3'h0, latched_mode_bits_out, hsize_in;
   logic [7:0] exc_vec_in = 8'h00, code_page_reg_out;
   logic [15:0] sr_wdata_in = 16'h0000, sp_out, status_word_out, pc_out, mem_addr_out, mem_wdata_out, mem_rdata_in;
   logic [15:0] pc_in, sp_in;
   logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, hrdata_out, rd;
   logic external_init_pin_out, external_init_pin_oe_out, chip_init_out, cpu_halt_out, exc_ack_out, branch_out;
   logic irq_block_out, sp_we_out, mem_req_out, mem_we_out, mem_ack_in, hreadyout_out, hresp_out;
   int fails = 0, cmp_count = 0, n;
   // The init pin is pulled low by whoever drives it; the bench stands in for the external source.
   assign external_init_pin_n_in = external_init_pin_oe_out ? external_init_pin_out : pin_drv;
   assign hready_in = hreadyout_out;
   assign hsize_in = 3'h2;
   assign pc_in = 16'hbeef;
   assign sp_in = 16'h0180;
   // Free-running 250 MHz system clock.
   always #2 clk_sys_in = ~clk_sys_in;
   exc_reset_sequencer u_exc_reset_sequencer (.*);
   exc_mem_model u_exc_mem_model (.clk_in(clk_sys_in), .rst_n_in, .req_in(mem_req_out), .we_in(mem_we_out),
      .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .slow_in(slow), .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d.", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Waits for a flag at a rising edge; a hang counts as a mismatch and ends the run.
   task automatic wait_hi(ref logic f);
      int k;
      k = 0;
      @(posedge clk_sys_in);
      while (f !== 1'b1) begin
         k++;
         if (k > 2000) begin
            fails++;
            wrap_up();
         end
         @(posedge clk_sys_in);
      end
   endtask
   // One single AHB-Lite word transfer; read data lands in rd.
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel_in <= 1'b1;
      haddr_in <= {24'h0, a};
      hwrite_in <= w;
      htrans_in <= 2'h2;
      wait_hi(hreadyout_out);
      htrans_in <= 2'h0;
      hwdata_in <= d;
      wait_hi(hreadyout_out);
      rd = hrdata_out;
      `CHK("hresp", 1'b0, hresp_out)
   endtask
   // Completes one instruction, either a plain one or a load-control one.
   task automatic insn(input logic load_control_insn);
      load_ctrl_insn_in <= load_control_insn;
      insn_done_in <= !load_control_insn;
      @(posedge clk_sys_in);
      load_ctrl_insn_in <= 1'b0;
      insn_done_in <= 1'b0;
      @(posedge clk_sys_in);
   endtask
   task automatic take_exc(input logic [7:0] v, input logic i, input logic [2:0] l);
      exc_vec_in <= v;
      exc_is_irq_in <= i;
      exc_irq_level_in <= l;
      exc_req_in <= 1'b1;
      wait_hi(exc_ack_out);
      exc_req_in <= 1'b0;
      wait_hi(branch_out);
      @(posedge clk_sys_in);
   endtask
   task automatic t_boot_min;
      wait_hi(branch_out);
      @(posedge clk_sys_in);
      `CHK("boot pc", 16'h1234, pc_out)
      `CHK("boot sr", 16'h0700, status_word_out)
      `CHK("boot mode", 3'h0, latched_mode_bits_out)
      `CHK("boot block", 1'b1, irq_block_out)
      ahb(1'b0, `EXC_REG_STATUS, 32'h0);
      `CHK("sr read", 32'h0000_0700, rd)
      ahb(1'b0, 8'h20, 32'h0);
      `CHK("unmapped read", 32'h0, rd)
   endtask
   task automatic t_exc_min;
      insn(1'b0);
      sr_wdata_in <= 16'h8300;
      sr_load_in <= 1'b1;
      @(posedge clk_sys_in);
      sr_load_in <= 1'b0;
      take_exc(8'h20, 1'b1, 3'h5);
      `CHK("push pc", 16'hbeef, u_exc_mem_model.mem[8'hbf])
      `CHK("push sr", 16'h8300, u_exc_mem_model.mem[8'hbe])
      `CHK("irq pc", 16'h4444, pc_out)
      `CHK("irq sr", 16'h0500, status_word_out)
      slow <= 1'b1;
      take_exc(8'h03, 1'b0, 3'h1);
      `CHK("div pc", 16'h5555, pc_out)
      `CHK("div sr", 16'h0500, status_word_out)
      insn(1'b1);
      `CHK("ldc block", 1'b1, irq_block_out)
      insn(1'b0);
      `CHK("ldc free", 1'b0, irq_block_out)
   endtask
   task automatic t_pin_max;
      u_exc_mem_model.mem[0] = 16'ha53c;
      u_exc_mem_model.mem[1] = 16'h2222;
      u_exc_mem_model.mem[6] = 16'h0007;
      u_exc_mem_model.mem[7] = 16'h6666;
      mode_select_pins_in <= 3'h5;
      pin_drv <= 1'b0;
      repeat (520) @(posedge clk_sys_in);
      `CHK("held init", 2'h3, {chip_init_out, cpu_halt_out})
      `CHK("held pc", 16'h0000, pc_out)
      pin_drv <= 1'b1;
      wait_hi(branch_out);
      @(posedge clk_sys_in);
      `CHK("max boot", {3'h5, 8'h3c, 16'h2222}, {latched_mode_bits_out, code_page_reg_out, pc_out})
      mode_select_pins_in <= 3'h0;
      insn(1'b0);
      take_exc(8'h03, 1'b0, 3'h0);
      `CHK("push cp", 16'h003c, u_exc_mem_model.mem[8'hbe])
      `CHK("max vec", {8'h07, 16'h6666}, {code_page_reg_out, pc_out})
   endtask
   task automatic t_wdog;
      ahb(1'b1, `EXC_REG_WDCTL, 32'h3);
      wdog_overflow_in <= 1'b1;
      @(posedge clk_sys_in);
      wdog_overflow_in <= 1'b0;
      wait_hi(external_init_pin_oe_out);
      `CHK("pin low", 1'b0, external_init_pin_n_in)
      n = 1;
      @(posedge clk_sys_in);
      while (external_init_pin_oe_out === 1'b1 && n < 300) begin
         n++;
         @(posedge clk_sys_in);
      end
      `CHK("pin drive", 132, n)
      wait_hi(branch_out);
      @(posedge clk_sys_in);
      `CHK("wdog boot pc", 16'ha53c, pc_out)
      ahb(1'b0, `EXC_REG_WDCTL, 32'h0);
      `CHK("wdog flag", 1'b1, rd[`EXC_WD_FLAG_BIT])
   endtask
   // Main sequence: reset held five cycles, then each scenario in turn.
   initial begin
      u_exc_mem_model.mem[0] = 16'h1234;
      u_exc_mem_model.mem[3] = 16'h5555;
      u_exc_mem_model.mem[8'h20] = 16'h4444;
      repeat (5) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      t_boot_min();
      t_exc_min();
      t_pin_max();
      t_wdog();
      wrap_up();
   end
endmodule
